// file: logic/brg_pkg.sv
// package for the bus-reset, gap-count and low-power control block
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package brg_pkg;
	// register offsets
	localparam logic [3:0] REG_PHY1 = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_IRQ_STAT = 4'h3;
	localparam logic [3:0] REG_IRQ_MASK = 4'h4;
	// field positions in the shared reset register
	localparam int REQ_BIT = 6;
	localparam int HOLDOFF_BIT = 7;
	localparam int GAP_LSB = 0;
	// reset values
	localparam logic [5:0] GAP_MAX = 6'h3f;
	localparam logic HOLDOFF_RESET = 1'b0;
	// bus reset length in cycles
	localparam int RESET_CYCLES = 16;
	// interrupt bits
	localparam int IRQ_RESET_DONE = 0;
	localparam int IRQ_GAP_FORCED = 1;
	localparam int IRQ_WAKE = 2;
	localparam int IRQ_W = 3;

	typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_INIT} brg_state_t;
	typedef enum logic [1:0] {PW_ACTIVE, PW_LOW, PW_DEEP} brg_pwr_t;

	typedef struct packed {
		logic valid;
		logic holdoff;
		logic [5:0] gap;
	} brg_cfg_t;

	typedef struct packed {
		logic write;
		logic read;
		logic [3:0] addr;
		logic [7:0] wdata;
	} brg_bus_t;
endpackage

// file: logic/brg_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module brg_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] stage1;

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			stage1 <= '0;
			o_sync <= '0;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// file: logic/brg_top.sv
// bus reset, gap count and automatic low-power control
`timescale 1ns/1ps
module brg_top #(
	parameter int PORTS = 2
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_rdata,
	// config packets and externally seen bus resets
	input wire logic i_cfg_rx_valid,
	input wire logic i_cfg_tx_valid,
	input wire logic i_cfg_holdoff,
	input wire logic [5:0] i_cfg_gap,
	input wire logic i_peer_bus_reset,
	// pins
	input wire logic i_link_power_status,
	input wire logic [PORTS-1:0] i_port_connected,
	input wire logic [PORTS-1:0] i_port_disabled,
	input wire logic [PORTS-1:0] i_port_suspended,
	input wire logic [PORTS-1:0] i_port_bias,
	input wire logic [PORTS-1:0] i_port_wake_interrupt_enable,
	// outputs
	output logic o_bus_reset,
	output logic o_bus_init,
	output logic [5:0] o_gap_count,
	output logic o_root_holdoff_flag,
	output logic o_clock_gen_en,
	output logic o_deepest_sleep_state,
	output logic o_link_active,
	output logic o_irq
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int SW = 1 + 5 * PORTS;
	logic [SW-1:0] pins_sync;
	logic link_power_status;
	logic [PORTS-1:0] p_con, p_dis, p_sus, p_bias, p_wie;

	brg_sync #(.W(SW)) u_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_link_power_status, i_port_connected, i_port_disabled,
			i_port_suspended, i_port_bias, i_port_wake_interrupt_enable}),
		.o_sync(pins_sync)
	);
	assign {link_power_status, p_con, p_dis, p_sus, p_bias, p_wie} = pins_sync;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		brg_pkg::brg_state_t st;
		brg_pkg::brg_pwr_t pwr;
		logic [4:0] cnt;
		logic [5:0] gap;
		logic holdoff;
		logic gap_updated;
		logic [PORTS-1:0] con_prev;
		logic [PORTS-1:0] sus_bias_prev;
		logic [brg_pkg::IRQ_W-1:0] irq_stat;
		logic [brg_pkg::IRQ_W-1:0] irq_mask;
		logic [7:0] rdata;
		logic irq;
		logic link_active;
		logic [1:0] warm;
		logic bus_reset;
		logic bus_init;
		logic clk_en;
		logic deep;
	} brg_top_state_t;

	brg_top_state_t s, next_s;
	brg_pkg::brg_bus_t bus;
	brg_pkg::brg_cfg_t cfg;
	logic req_write;
	logic ports_idle;
	logic deep_ok;
	logic port_event;
	logic [brg_pkg::IRQ_W-1:0] ev;
	logic reset_start;
	logic reset_end;
	logic [PORTS-1:0] deep_each;

	assign bus = '{write: i_write, read: i_read, addr: i_addr,
		wdata: i_wdata};
	assign cfg = '{valid: i_cfg_rx_valid | i_cfg_tx_valid,
		holdoff: i_cfg_holdoff, gap: i_cfg_gap};
	assign req_write = bus.write && bus.addr == brg_pkg::REG_PHY1 &&
		bus.wdata[brg_pkg::REQ_BIT];

	// ---------------------------------------------------------------
	// port activity
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < PORTS; g++)
		begin : g_port
			assign deep_each[g] = !p_con[g] ||
				(p_dis[g] && !p_wie[g]);
		end
	endgenerate

	assign ports_idle = &(~p_con | p_dis | p_sus);
	assign deep_ok = &deep_each;
	// port events needing a response
	assign port_event = |(p_sus & p_bias & ~s.sus_bias_prev) ||
		|(p_sus & s.con_prev & ~p_con) ||
		|(~p_dis & p_con & ~s.con_prev);

	assign reset_start = s.st == brg_pkg::ST_IDLE &&
		(req_write || i_peer_bus_reset);
	assign reset_end = s.st == brg_pkg::ST_RESET &&
		s.cnt == 5'(brg_pkg::RESET_CYCLES - 1);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		ev = '0;
		next_s.con_prev = p_con;
		next_s.sus_bias_prev = p_sus & p_bias;
		// pin levels valid once both sync stages have filled
		next_s.warm = {s.warm[0], 1'b1};
		// gap count and holdoff loading
		if (req_write)
		begin
			next_s.gap = bus.wdata[brg_pkg::GAP_LSB +: 6];
			next_s.holdoff = bus.wdata[brg_pkg::HOLDOFF_BIT];
			next_s.gap_updated = 1'b1;
		end
		else if (cfg.valid)
		begin
			next_s.gap = cfg.gap;
			next_s.holdoff = cfg.holdoff;
			next_s.gap_updated = 1'b1;
		end
		// reset sequencer
		unique case (s.st)
			brg_pkg::ST_IDLE:
			begin
				if (reset_start)
				begin
					next_s.st = brg_pkg::ST_RESET;
					next_s.cnt = '0;
					next_s.pwr = brg_pkg::PW_ACTIVE;
					// no update since the last reset forces maximum
					if (!s.gap_updated && !req_write &&
						!cfg.valid)
					begin
						next_s.gap = brg_pkg::GAP_MAX;
						ev[brg_pkg::IRQ_GAP_FORCED] = 1'b1;
					end
					next_s.gap_updated = 1'b0;
				end
			end
			brg_pkg::ST_RESET:
			begin
				next_s.cnt = s.cnt + 5'd1;
				if (reset_end)
				begin
					next_s.st = brg_pkg::ST_INIT;
					next_s.cnt = '0;
				end
			end
			brg_pkg::ST_INIT:
			begin
				next_s.cnt = s.cnt + 5'd1;
				if (s.cnt == 5'(brg_pkg::RESET_CYCLES - 1))
				begin
					next_s.st = brg_pkg::ST_IDLE;
					ev[brg_pkg::IRQ_RESET_DONE] = 1'b1;
				end
			end
		endcase
		// low-power control
		unique case (s.pwr)
			brg_pkg::PW_ACTIVE:
			begin
				if (!link_power_status && ports_idle && s.st == brg_pkg::ST_IDLE &&
					!reset_start && s.warm[1])
				begin
					next_s.pwr = deep_ok ? brg_pkg::PW_DEEP
						: brg_pkg::PW_LOW;
					next_s.link_active = 1'b0;
				end
				else if (link_power_status)
					next_s.link_active = 1'b1;
			end
			brg_pkg::PW_LOW, brg_pkg::PW_DEEP:
			begin
				if (link_power_status)
				begin
					next_s.pwr = brg_pkg::PW_ACTIVE;
					next_s.link_active = 1'b1;
					ev[brg_pkg::IRQ_WAKE] = 1'b1;
				end
				else if (port_event && s.pwr == brg_pkg::PW_LOW)
				begin
					next_s.pwr = brg_pkg::PW_ACTIVE;
					next_s.link_active = 1'b0;
					ev[brg_pkg::IRQ_WAKE] = 1'b1;
				end
				else if (s.pwr == brg_pkg::PW_LOW && deep_ok)
					next_s.pwr = brg_pkg::PW_DEEP;
				else if (s.pwr == brg_pkg::PW_DEEP && !deep_ok)
					next_s.pwr = brg_pkg::PW_LOW;
			end
			default:
				next_s.pwr = brg_pkg::PW_ACTIVE;
		endcase
		// registered copies of the decoded outputs
		next_s.bus_reset = next_s.st == brg_pkg::ST_RESET;
		next_s.bus_init = next_s.st == brg_pkg::ST_INIT;
		next_s.clk_en = next_s.pwr == brg_pkg::PW_ACTIVE;
		next_s.deep = next_s.pwr == brg_pkg::PW_DEEP;
		// register writes; set wins over write-one clear
		if (bus.write && bus.addr == brg_pkg::REG_IRQ_MASK)
			next_s.irq_mask = bus.wdata[brg_pkg::IRQ_W-1:0];
		if (bus.write && bus.addr == brg_pkg::REG_IRQ_STAT)
			next_s.irq_stat = s.irq_stat & ~bus.wdata[brg_pkg::IRQ_W-1:0];
		next_s.irq_stat = next_s.irq_stat | ev;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
		// read data, valid the cycle after the strobe
		next_s.rdata = '0;
		if (bus.read)
		begin
			unique case (bus.addr)
				brg_pkg::REG_PHY1:
					next_s.rdata = {s.holdoff, 1'b0, s.gap};
				brg_pkg::REG_STATUS:
					next_s.rdata = {3'b000, s.gap_updated, s.link_active,
						s.pwr, s.st != brg_pkg::ST_IDLE};
				brg_pkg::REG_IRQ_STAT:
					next_s.rdata = 8'(s.irq_stat);
				brg_pkg::REG_IRQ_MASK:
					next_s.rdata = 8'(s.irq_mask);
				default:
					next_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s <= '0;
			s.st <= brg_pkg::ST_IDLE;
			s.pwr <= brg_pkg::PW_ACTIVE;
			s.gap <= brg_pkg::GAP_MAX;
			s.holdoff <= brg_pkg::HOLDOFF_RESET;
			s.clk_en <= 1'b1;
		end
		else
			s <= next_s;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_rdata = s.rdata;
	assign o_bus_reset = s.bus_reset;
	assign o_bus_init = s.bus_init;
	assign o_gap_count = s.gap;
	assign o_root_holdoff_flag = s.holdoff;
	assign o_clock_gen_en = s.clk_en;
	assign o_deepest_sleep_state = s.deep;
	assign o_link_active = s.link_active;
	assign o_irq = s.irq;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence req_seen;
		req_write && s.st == brg_pkg::ST_IDLE;
	endsequence

	sequence plain_reset;
		reset_start && !s.gap_updated && !req_write && !cfg.valid;
	endsequence

	sequence updated_reset;
		reset_start && s.gap_updated && !req_write && !cfg.valid;
	endsequence

	a_req_starts_reset: assert property (
		req_seen |=> o_bus_reset)
		else $error("request write did not start bus reset");
	a_reset_then_init: assert property (
		$rose(o_bus_reset) |-> ##16 o_bus_init)
		else $error("init did not follow reset");
	a_req_loads_gap: assert property (
		req_write |=> o_gap_count == $past(i_wdata[5:0]))
		else $error("gap not loaded by request write");
	a_cfg_loads_gap: assert property (
		cfg.valid && !req_write && !reset_start |=>
		o_gap_count == $past(i_cfg_gap))
		else $error("config packet did not load gap");
	a_no_req_write: assert property (
		bus.write && bus.addr == brg_pkg::REG_PHY1 &&
		!i_wdata[brg_pkg::REQ_BIT] && !cfg.valid && !reset_start &&
		s.st == brg_pkg::ST_IDLE |=>
		$stable(o_gap_count) && $stable(o_root_holdoff_flag) &&
		!o_bus_reset)
		else $error("write without request changed gap");
	a_sleep_needs_idle: assert property (
		$fell(o_clock_gen_en) |-> !$past(link_power_status) && $past(ports_idle))
		else $error("sleep entered while not idle");
	a_wake_on_lps: assert property (
		link_power_status && !o_clock_gen_en |=> o_clock_gen_en && o_link_active)
		else $error("no wake on link power status");
	a_port_wake_link: assert property (
		$rose(o_clock_gen_en) && !$past(link_power_status) |-> !o_link_active)
		else $error("port wake activated link");
	a_deep_cond: assert property (
		o_deepest_sleep_state |-> $past(deep_ok))
		else $error("deepest sleep without condition");
	a_gap_forced: assert property (
		plain_reset |=> o_gap_count == brg_pkg::GAP_MAX)
		else $error("gap not forced to maximum");
	a_gap_kept: assert property (
		updated_reset |=> $stable(o_gap_count))
		else $error("updated gap lost on reset");
	a_init_ends: assert property (
		$rose(o_bus_init) |-> ##16 !o_bus_init && !o_bus_reset)
		else $error("init did not end");
	a_req_holdoff: assert property (
		req_write |=> o_root_holdoff_flag == $past(i_wdata[7]))
		else $error("holdoff not loaded by request write");
	a_no_early_sleep: assert property (
		!s.warm[1] |=> o_clock_gen_en)
		else $error("sleep before pins synchronised");
	a_rdata_idle: assert property (
		!i_read |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule

// file: tb/brg_far.sv
// far-side model: peer nodes, link controller pins
`timescale 1ns/1ps
module brg_far (
	// clock
	input wire logic i_clk,
	// towards the block
	output logic o_rx,
	output logic o_tx,
	output logic o_holdoff,
	output logic [5:0] o_gap,
	output logic o_peer_reset,
	output logic o_lps,
	output logic [1:0] o_conn,
	output logic [1:0] o_susp,
	output logic [1:0] o_bias,
	output logic [1:0] o_dis,
	output logic [1:0] o_wake_en,
	// link controller reset, released before the block's
	output logic o_link_reset_n
);
	initial
	begin
		o_rx = 1'b0;
		o_tx = 1'b0;
		o_holdoff = 1'b1;
		o_gap = 6'h2a;
		o_peer_reset = 1'b0;
		o_lps = 1'b1;
		o_conn = 2'b00;
		o_susp = 2'b00;
		o_bias = 2'b00;
		o_dis = 2'b00;
		o_wake_en = 2'b00;
		o_link_reset_n = 1'b0;
	end
	// port disable and wake enable levels
	task automatic ctrl(input logic [1:0] d, input logic [1:0] w);
		@(posedge i_clk);
		o_dis <= d;
		o_wake_en <= w;
	endtask
	task automatic link_up();
		@(posedge i_clk);
		o_link_reset_n <= 1'b1;
	endtask
	// -----------------------------------
	// one-cycle config packet; fields scrambled after it
	// -----------------------------------
	task automatic cfg(input logic tx, input logic h, input logic [5:0] g);
		@(posedge i_clk);
		o_rx <= !tx;
		o_tx <= tx;
		o_holdoff <= h;
		o_gap <= g;
		@(posedge i_clk);
		o_rx <= 1'b0;
		o_tx <= 1'b0;
		o_holdoff <= !h;
		o_gap <= ~g;
	endtask
	task automatic peer_reset();
		@(posedge i_clk);
		o_peer_reset <= 1'b1;
		@(posedge i_clk);
		o_peer_reset <= 1'b0;
	endtask
	// link status and port levels
	task automatic pins(input logic l, input logic [1:0] c, s, b);
		@(posedge i_clk);
		o_lps <= l;
		o_conn <= c;
		o_susp <= s;
		o_bias <= b;
	endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the bus reset and low-power block
`timescale 1ns/1ps
module testbench;
	logic i_clk, i_reset_n, i_write, i_read;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata;
	logic rx, tx, hold, pr, link_power_status, o_bus_reset, o_bus_init;
	logic o_root_holdoff_flag, o_clock_gen_en, o_deepest_sleep_state;
	logic o_link_active, o_irq;
	logic [5:0] gap, o_gap_count;
	logic [1:0] conn, susp, bias;
	logic [1:0] dis, wie;
	logic lrn;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	brg_far far (.i_clk(i_clk), .o_rx(rx), .o_tx(tx), .o_holdoff(hold),
		.o_gap(gap), .o_peer_reset(pr), .o_lps(link_power_status), .o_conn(conn),
		.o_susp(susp), .o_bias(bias), .o_dis(dis), .o_wake_en(wie),
		.o_link_reset_n(lrn));
	brg_top #(.PORTS(2)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
		.i_read(i_read), .o_rdata(o_rdata), .i_cfg_rx_valid(rx),
		.i_cfg_tx_valid(tx), .i_cfg_holdoff(hold), .i_cfg_gap(gap),
		.i_peer_bus_reset(pr), .i_link_power_status(link_power_status),
		.i_port_connected(conn), .i_port_disabled(dis),
		.i_port_suspended(susp), .i_port_bias(bias),
		.i_port_wake_interrupt_enable(wie), .o_bus_reset(o_bus_reset),
		.o_bus_init(o_bus_init), .o_gap_count(o_gap_count),
		.o_root_holdoff_flag(o_root_holdoff_flag),
		.o_clock_gen_en(o_clock_gen_en),
		.o_deepest_sleep_state(o_deepest_sleep_state),
		.o_link_active(o_link_active), .o_irq(o_irq));
	// -----------------------------------
	// shared tasks
	// -----------------------------------
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clk);
		i_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clk);
		i_read <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	// wait for the reset sequence to run out
	task automatic settle();
		tick(2);
		for (int i = 0; i < 60; i++)
		begin
			if (o_bus_reset === 1'b0 && o_bus_init === 1'b0) break;
			tick(1);
		end
	endtask
	task automatic waitclk(input logic v);
		for (int i = 0; i < 20; i++)
		begin
			tick(1);
			if (o_clock_gen_en === v) break;
		end
	endtask
	task automatic t_request();
		logic [7:0] d;
		far.cfg(1'b1, 1'b1, 6'h0a);
		rd(brg_pkg::REG_PHY1, d);
		chk(d === 8'h8a, "reg1 after sent packet");
		wr(brg_pkg::REG_PHY1, d | 8'h40);
		chk(o_bus_reset === 1'b1 && o_gap_count === 6'h0a, "start");
		chk(o_root_holdoff_flag === 1'b1, "holdoff loaded");
		tick(16);
		chk(o_bus_reset === 1'b0 && o_bus_init === 1'b1, "init");
		settle();
		chk(o_gap_count === 6'h0a, "own gap kept");
		wr(brg_pkg::REG_PHY1, 8'h05);
		tick(2);
		chk(o_gap_count === 6'h0a && o_bus_reset === 1'b0, "no req");
	endtask
	task automatic t_force();
		logic [7:0] d;
		far.peer_reset();
		settle();
		chk(o_gap_count === 6'h3f, "gap forced");
		wr(brg_pkg::REG_IRQ_MASK, 8'h02);
		tick(2);
		chk(o_irq === 1'b1, "irq raised");
		wr(brg_pkg::REG_IRQ_STAT, 8'h02);
		tick(2);
		chk(o_irq === 1'b0, "irq cleared");
		far.cfg(1'b0, 1'b0, 6'h12);
		tick(1);
		chk(o_gap_count === 6'h12 && o_root_holdoff_flag === 1'b0, "rx");
		far.peer_reset();
		settle();
		chk(o_gap_count === 6'h12, "updated gap kept");
		wr(brg_pkg::REG_PHY1, 8'h7f);
		chk(o_gap_count === 6'h3f && o_bus_reset === 1'b1, "write");
		settle();
		rd(4'hf, d);
		chk(d === 8'h00, "unmapped read");
	endtask
	task automatic t_lowpower();
		far.pins(1'b0, 2'b00, 2'b00, 2'b00);
		waitclk(1'b0);
		chk(o_clock_gen_en === 1'b0, "sleep");
		chk(o_deepest_sleep_state === 1'b1, "deep");
		far.pins(1'b1, 2'b00, 2'b00, 2'b00);
		waitclk(1'b1);
		chk(o_link_active === 1'b1, "lps wake");
		chk(o_deepest_sleep_state === 1'b0, "deep left");
		far.pins(1'b1, 2'b11, 2'b11, 2'b00);
		far.pins(1'b0, 2'b11, 2'b11, 2'b00);
		waitclk(1'b0);
		chk(o_clock_gen_en === 1'b0, "suspended sleep");
		chk(o_deepest_sleep_state === 1'b0, "light sleep");
		far.pins(1'b0, 2'b11, 2'b11, 2'b01);
		waitclk(1'b1);
		chk(o_clock_gen_en === 1'b1, "bias wake");
		chk(o_link_active === 1'b0, "link stays off");
		far.ctrl(2'b11, 2'b11);
		far.pins(1'b0, 2'b11, 2'b00, 2'b00);
		tick(4);
		chk(o_clock_gen_en === 1'b0, "disabled ports idle");
		chk(o_deepest_sleep_state === 1'b0, "wake enabled");
		far.ctrl(2'b11, 2'b00);
		tick(4);
		chk(o_deepest_sleep_state === 1'b1, "disabled deep");
	endtask
	task automatic end_of_test();
		$display("mismatches %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// -----------------------------------
	// clock, timeout, main sequence
	// -----------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	initial
	begin
		i_reset_n = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_write = 1'b0;
		i_read = 1'b0;
		tick(10);
		chk(o_gap_count === 6'h3f && o_root_holdoff_flag === 1'b0, "rv");
		chk(o_clock_gen_en === 1'b1 && o_irq === 1'b0, "reset outputs");
		far.link_up();
		@(posedge i_clk);
		chk(lrn === 1'b1 && i_reset_n === 1'b0, "link first");
		i_reset_n <= 1'b1;
		tick(3);
		t_request();
		t_force();
		t_lowpower();
		end_of_test();
	end
endmodule
